// >>> rtl/dpmc_top.sv
/*
  Dancer roller tension control: mode decode, enable gating, feedback
  scaling, speed command combination and flag outputs, with a classic
  Wishbone register slave. Assumes the PID arithmetic sits outside and
  returns its correction in 0.1 % steps, and that all inputs are
  synchronous to clk_i.
*/
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "dpmc_consts.svh"

module dpmc_top
  import dpmc_pkg::*;
#(
  parameter int N_IN = 7,
  parameter int N_OUT = 3,
  parameter int UPDATE_CYC = `DPMC_UPDATE_CYC
) (
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic rst_i, // Synchronous reset, high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte lanes
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic [N_IN-1:0] in_term_i, // Digital input terminals
  input wire logic [`DPMC_FB_W-1:0] feedback_raw_i, // Dancer position code
  input wire logic [15:0] main_speed_i, // Main speed command
  input wire logic [15:0] output_freq_i, // Present output frequency
  input wire logic running_i, // Drive is running
  input wire logic dir_forward_i, // Indicated direction is forward
  input wire logic signed [15:0] pid_correction_i, // Loop correction
  output logic [N_OUT-1:0] out_term_o, // Output terminals, high = on
  output logic [15:0] speed_cmd_o, // Resulting speed command
  output logic [15:0] set_point_o, // Effective set point
  output logic [15:0] feedback_pct_o, // Measured value
  output logic pid_reverse_o, // Reverse action selected
  output logic tension_active_o // Loop-active state
);

  // Configuration storage
  logic [7:0] action_selector; // Loop action selector
  dpmc_sel_type input_terminal_function_selectors [N_IN]; // Input codes
  dpmc_sel_type output_terminal_function_selectors [N_OUT]; // Output codes
  logic [15:0] upper_limit_setting; // Upper limit
  logic [15:0] lower_limit_setting; // Lower limit
  logic [15:0] set_point_setting; // Set point
  logic [1:0] feedback_scaling_selector; // Feedback range
  logic [15:0] gain_frequency; // 100 % frequency
  logic [15:0] bias_point_frequency; // 0 % frequency
  logic [15:0] auto_switchover_frequency; // Stored only

  // Loop state
  logic loop_enable_in; // Resolved enable
  logic enable_assigned; // Some input carries the enable
  logic enable_level; // OR of enable terminals
  logic loop_enable_q; // Enable one clock ago
  logic tension_mode; // Tension control in force
  logic latch_valid; // Latched base speed in use
  logic [15:0] latched_speed; // Frequency caught at enable
  logic upper_limit_flag; // Feedback above upper limit
  logic lower_limit_flag; // Feedback below lower limit
  logic direction_forward_flag; // Forward rotation indication
  logic [15:0] fb_pct; // Scaled feedback, combinational
  logic [15:0] base_speed; // Speed the correction adds to
  logic [15:0] next_speed; // Speed command for next update
  logic [$clog2(UPDATE_CYC+1)-1:0] upd_cnt; // Update period counter
  logic upd_tick; // One clock per update period
  logic [31:0] rd_word; // Read mux output
  logic wr_en; // Write strobe at the acknowledged edge

  // Ratio divider
  dpmc_div_state_type div_state; // Divider sequencer
  logic [27:0] div_num; // Shifting dividend
  logic [16:0] div_rem; // Partial remainder
  logic [16:0] div_den; // Divisor: gain minus bias
  logic [27:0] div_quot; // Quotient bits
  logic [4:0] div_cnt; // Steps left
  logic [12:0] ratio_q; // Main speed ratio, 1.0 = 4096
  logic [16:0] rem_try; // Remainder with next bit

  // Action code classes
  function automatic logic is_tension(input logic [7:0] code);
    return code >= `DPMC_ACT_REV_FIXED && code <= `DPMC_ACT_FWD_RATIO;
  endfunction

  function automatic logic is_ratio(input logic [7:0] code);
    return code == `DPMC_ACT_REV_RATIO || code == `DPMC_ACT_FWD_RATIO;
  endfunction

  // Terminal code to scaled percent, clamped at full scale
  function automatic logic [15:0] fb_scale(input logic [`DPMC_FB_W-1:0] raw,
                                           input logic [1:0] sel);
    logic [10:0] code;
    logic [21:0] prod;
    logic [15:0] pct;
    code = '0;
    prod = '0;
    unique case (sel)
      `DPMC_SCALE_5V: begin
        prod = 22'(raw) * 22'(`DPMC_K_5V);
      end
      `DPMC_SCALE_10V: begin
        prod = 22'(raw) * 22'(`DPMC_K_10V);
      end
      default: begin // 4-20 mA, also the unused code 3
        code = (raw < `DPMC_FB_4MA) ? 11'h000 : 11'(raw - `DPMC_FB_4MA);
        prod = 22'(code) * 22'(`DPMC_K_MA);
      end
    endcase
    pct = 16'(prod >> `DPMC_K_SHIFT);
    return (pct > `DPMC_PCT_FULL) ? `DPMC_PCT_FULL : pct;
  endfunction

  // One output terminal from its function code
  function automatic logic out_level(input logic [7:0] code, input logic up,
                                     input logic lo, input logic dir,
                                     input logic act);
    logic neg;
    logic [7:0] fn;
    logic lvl;
    neg = code >= `DPMC_OUT_FN_NEG;
    fn = neg ? 8'(code - `DPMC_OUT_FN_NEG) : code;
    unique case (fn)
      `DPMC_OUT_FN_UPPER: lvl = up;
      `DPMC_OUT_FN_LOWER: lvl = lo;
      `DPMC_OUT_FN_DIR: lvl = dir;
      `DPMC_OUT_FN_ACTIVE: lvl = act;
      default: lvl = 1'b0; // Functions not owned by this block
    endcase
    return lvl ^ neg;
  endfunction

  // Byte-lane merge for 16-bit settings
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] dat,
                                       input logic [3:0] sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Enable resolution and mode decode
  always_comb begin
    enable_assigned = 1'b0;
    enable_level = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (input_terminal_function_selectors[i] == `DPMC_IN_FN_ENABLE) begin
        enable_assigned = 1'b1;
        enable_level = enable_level | in_term_i[i];
      end
    end
    loop_enable_in = enable_assigned ? enable_level : 1'b1;
    tension_mode = is_tension(action_selector) && loop_enable_in;
    fb_pct = fb_scale(feedback_raw_i, feedback_scaling_selector);
  end

  // Upper and lower limits, direction; 9999 switches a limit off
  always_comb begin
    upper_limit_flag = tension_mode && upper_limit_setting != `DPMC_NONE
                       && fb_pct > upper_limit_setting;
    lower_limit_flag = tension_mode && lower_limit_setting != `DPMC_NONE
                       && fb_pct < lower_limit_setting;
    direction_forward_flag = running_i && dir_forward_i;
  end

  // Speed command: base plus correction scaled to the bias..gain span
  always_comb begin
    logic signed [16:0] span;
    logic signed [47:0] cprod;
    logic signed [27:0] corr_f;
    logic signed [40:0] rprod;
    logic signed [28:0] sum;
    span = 17'(signed'({1'b0, gain_frequency}) - signed'({1'b0, bias_point_frequency}));
    if (span < 0) begin
      span = '0; // Inverted span gives no correction
    end
    base_speed = latch_valid ? latched_speed : main_speed_i;
    cprod = 48'(pid_correction_i) * 48'(span)
            * 48'(signed'({1'b0, `DPMC_DIV1000_K}));
    corr_f = 28'(cprod >>> `DPMC_DIV1000_SHIFT);
    rprod = 41'(corr_f) * 41'(signed'({1'b0, ratio_q}));
    if (is_ratio(action_selector)) begin
      corr_f = 28'(rprod >>> `DPMC_RATIO_FRAC);
    end
    sum = 29'(signed'({1'b0, base_speed})) + 29'(corr_f);
    if (!tension_mode) begin
      next_speed = main_speed_i;
    end else if (sum < 0) begin
      next_speed = '0;
    end else if (sum > 29'(`DPMC_SPEED_MAX)) begin
      next_speed = `DPMC_SPEED_MAX;
    end else begin
      next_speed = 16'(sum);
    end
  end

  // Update period timebase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_cnt <= '0;
      upd_tick <= 1'b0;
    end else if (upd_cnt == ($bits(upd_cnt))'(UPDATE_CYC - 1)) begin
      upd_cnt <= '0;
      upd_tick <= 1'b1;
    end else begin
      upd_cnt <= upd_cnt + 1'b1;
      upd_tick <= 1'b0;
    end
  end

  // Catch the output frequency when enable rises during a run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_enable_q <= 1'b0;
      latch_valid <= 1'b0;
      latched_speed <= '0;
    end else begin
      loop_enable_q <= loop_enable_in;
      if (!loop_enable_in || !running_i || !is_tension(action_selector)) begin
        latch_valid <= 1'b0;
      end else if (!loop_enable_q) begin
        latch_valid <= 1'b1;
        latched_speed <= output_freq_i;
      end
    end
  end

  // Main speed ratio (base_speed - bias) / (gain - bias), serial divider
  assign rem_try = {div_rem[15:0], div_num[27]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_state <= DPMC_DIV_IDLE;
      div_num <= '0;
      div_rem <= '0;
      div_den <= '0;
      div_quot <= '0;
      div_cnt <= '0;
      ratio_q <= `DPMC_RATIO_ONE;
    end else begin
      unique case (div_state)
        DPMC_DIV_IDLE: begin
          if (upd_tick) begin
            if (base_speed <= bias_point_frequency) begin
              ratio_q <= '0;
            end else if (base_speed >= gain_frequency) begin
              ratio_q <= `DPMC_RATIO_ONE;
            end else begin
              div_num <= {16'(base_speed - bias_point_frequency),
                          `DPMC_RATIO_FRAC'(0)};
              div_den <= 17'(gain_frequency - bias_point_frequency);
              div_rem <= '0;
              div_quot <= '0;
              div_cnt <= `DPMC_DIV_STEPS;
              div_state <= DPMC_DIV_RUN;
            end
          end
        end
        DPMC_DIV_RUN: begin
          div_num <= {div_num[26:0], 1'b0};
          if (rem_try >= div_den) begin
            div_rem <= rem_try - div_den;
            div_quot <= {div_quot[26:0], 1'b1};
          end else begin
            div_rem <= rem_try;
            div_quot <= {div_quot[26:0], 1'b0};
          end
          if (div_cnt == '0) begin
            ratio_q <= 13'(rem_try >= div_den ? {div_quot[11:0], 1'b1}
                                              : {div_quot[11:0], 1'b0});
            div_state <= DPMC_DIV_IDLE;
          end else begin
            div_cnt <= div_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // Outputs refreshed once per update period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_term_o <= '0;
      speed_cmd_o <= '0;
      set_point_o <= `DPMC_SP_FIXED;
      feedback_pct_o <= '0;
      pid_reverse_o <= 1'b0;
      tension_active_o <= 1'b0;
    end else if (upd_tick) begin
      for (int i = 0; i < N_OUT; i++) begin
        out_term_o[i] <= out_level(output_terminal_function_selectors[i],
                                   upper_limit_flag, lower_limit_flag,
                                   direction_forward_flag, tension_mode);
      end
      speed_cmd_o <= next_speed;
      set_point_o <= (set_point_setting == `DPMC_NONE) ? `DPMC_SP_FIXED
                                                       : set_point_setting;
      feedback_pct_o <= fb_pct;
      pid_reverse_o <= action_selector == `DPMC_ACT_REV_FIXED
                       || action_selector == `DPMC_ACT_REV_RATIO;
      tension_active_o <= tension_mode;
    end
  end

  // Register writes take effect on the edge where ack is seen high
  assign wr_en = cyc_i && stb_i && we_i && ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      action_selector <= `DPMC_SEL_RST;
      for (int i = 0; i < N_IN; i++) begin
        input_terminal_function_selectors[i] <= `DPMC_SEL_RST;
      end
      for (int i = 0; i < N_OUT; i++) begin
        output_terminal_function_selectors[i] <= `DPMC_SEL_RST;
      end
      upper_limit_setting <= `DPMC_NONE;
      lower_limit_setting <= `DPMC_NONE;
      set_point_setting <= `DPMC_NONE;
      feedback_scaling_selector <= `DPMC_SCALE_MA;
      gain_frequency <= `DPMC_GAIN_RST;
      bias_point_frequency <= `DPMC_BIAS_RST;
      auto_switchover_frequency <= `DPMC_NONE;
    end else if (wr_en) begin
      if (adr_i == `DPMC_REG_ACTION && sel_i[0]) begin
        action_selector <= dat_i[7:0];
      end
      for (int i = 0; i < N_IN; i++) begin
        if (adr_i == 8'(`DPMC_REG_IN_SEL0 + 4 * i) && sel_i[0]) begin
          input_terminal_function_selectors[i] <= dat_i[7:0];
        end
      end
      for (int i = 0; i < N_OUT; i++) begin
        if (adr_i == 8'(`DPMC_REG_OUT_SEL0 + 4 * i) && sel_i[0]) begin
          output_terminal_function_selectors[i] <= dat_i[7:0];
        end
      end
      unique case (adr_i)
        `DPMC_REG_UPPER: upper_limit_setting <= wr16(upper_limit_setting, dat_i, sel_i);
        `DPMC_REG_LOWER: lower_limit_setting <= wr16(lower_limit_setting, dat_i, sel_i);
        `DPMC_REG_SETPT: set_point_setting <= wr16(set_point_setting, dat_i, sel_i);
        `DPMC_REG_GAIN: gain_frequency <= wr16(gain_frequency, dat_i, sel_i);
        `DPMC_REG_BIAS: bias_point_frequency <= wr16(bias_point_frequency, dat_i, sel_i);
        `DPMC_REG_AUTOSW: begin
          auto_switchover_frequency <= wr16(auto_switchover_frequency, dat_i, sel_i);
        end
        `DPMC_REG_SCALE: begin
          if (sel_i[0]) begin
            feedback_scaling_selector <= dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    unique case (adr_i)
      `DPMC_REG_ACTION: rd_word = 32'(action_selector);
      `DPMC_REG_UPPER: rd_word = 32'(upper_limit_setting);
      `DPMC_REG_LOWER: rd_word = 32'(lower_limit_setting);
      `DPMC_REG_SETPT: rd_word = 32'(set_point_setting);
      `DPMC_REG_SCALE: rd_word = 32'(feedback_scaling_selector);
      `DPMC_REG_GAIN: rd_word = 32'(gain_frequency);
      `DPMC_REG_BIAS: rd_word = 32'(bias_point_frequency);
      `DPMC_REG_AUTOSW: rd_word = 32'(auto_switchover_frequency);
      `DPMC_REG_FBPCT: rd_word = 32'(feedback_pct_o);
      `DPMC_REG_SPEED: rd_word = 32'(speed_cmd_o);
      `DPMC_REG_STATUS: begin
        rd_word[`DPMC_ST_ACTIVE] = tension_mode;
        rd_word[`DPMC_ST_UPPER] = upper_limit_flag;
        rd_word[`DPMC_ST_LOWER] = lower_limit_flag;
        rd_word[`DPMC_ST_DIR] = direction_forward_flag;
        rd_word[`DPMC_ST_ASSIGNED] = enable_assigned;
        rd_word[`DPMC_ST_LATCHED] = latch_valid;
        rd_word[`DPMC_ST_ENABLE] = loop_enable_in;
      end
      default: begin
        for (int i = 0; i < N_IN; i++) begin
          if (adr_i == 8'(`DPMC_REG_IN_SEL0 + 4 * i)) begin
            rd_word = 32'(input_terminal_function_selectors[i]);
          end
        end
        for (int i = 0; i < N_OUT; i++) begin
          if (adr_i == 8'(`DPMC_REG_OUT_SEL0 + 4 * i)) begin
            rd_word = 32'(output_terminal_function_selectors[i]);
          end
        end
      end
    endcase
  end

  // Wishbone answer: one wait state, ack held one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) begin
        dat_o <= rd_word;
      end
    end
  end

endmodule

// >>> rtl/dpmc_consts.svh
/*
  Constants of the dancer tension control block: codes, register offsets,
  reset values, scaling figures and timing. Included by the top module;
  it holds definitions only.
*/
`ifndef DPMC_CONSTS_SVH
`define DPMC_CONSTS_SVH

// Action selector codes
`define DPMC_ACT_REV_FIXED 8'h28
`define DPMC_ACT_FWD_FIXED 8'h29
`define DPMC_ACT_REV_RATIO 8'h2A
`define DPMC_ACT_FWD_RATIO 8'h2B

// Terminal function codes
`define DPMC_IN_FN_ENABLE 8'h0E
`define DPMC_OUT_FN_LOWER 8'h0E
`define DPMC_OUT_FN_UPPER 8'h0F
`define DPMC_OUT_FN_DIR 8'h10
`define DPMC_OUT_FN_ACTIVE 8'h2F
`define DPMC_OUT_FN_NEG 8'h64

// Settings in 0.1 % steps, frequencies in 0.01 Hz steps
`define DPMC_NONE 16'h270F
`define DPMC_SP_FIXED 16'h01F4
`define DPMC_PCT_FULL 16'h03E8
`define DPMC_GAIN_RST 16'h1388
`define DPMC_BIAS_RST 16'h0000
`define DPMC_SEL_RST 8'h00
`define DPMC_SPEED_MAX 16'hFFFF

// Feedback scaling selector values
`define DPMC_SCALE_MA 2'h0
`define DPMC_SCALE_5V 2'h1
`define DPMC_SCALE_10V 2'h2

// Feedback converter: 10-bit code, full code = 20 mA or 10 V
`define DPMC_FB_W 10
`define DPMC_FB_4MA 10'h0CD
`define DPMC_K_MA 11'h4E2
`define DPMC_K_5V 11'h7D0
`define DPMC_K_10V 11'h3E8
`define DPMC_K_SHIFT 10

// Percent to fraction: divide by 1000 as multiply and shift
`define DPMC_DIV1000_K 12'h419
`define DPMC_DIV1000_SHIFT 20
`define DPMC_RATIO_FRAC 12
`define DPMC_RATIO_ONE 13'h1000
`define DPMC_DIV_STEPS 5'h1B

// Register byte offsets
`define DPMC_REG_ACTION 8'h00
`define DPMC_REG_IN_SEL0 8'h04
`define DPMC_REG_OUT_SEL0 8'h20
`define DPMC_REG_UPPER 8'h2C
`define DPMC_REG_LOWER 8'h30
`define DPMC_REG_SETPT 8'h34
`define DPMC_REG_SCALE 8'h38
`define DPMC_REG_GAIN 8'h3C
`define DPMC_REG_BIAS 8'h40
`define DPMC_REG_AUTOSW 8'h44
`define DPMC_REG_STATUS 8'h48
`define DPMC_REG_FBPCT 8'h4C
`define DPMC_REG_SPEED 8'h50

// Status bit positions
`define DPMC_ST_ACTIVE 0
`define DPMC_ST_UPPER 1
`define DPMC_ST_LOWER 2
`define DPMC_ST_DIR 3
`define DPMC_ST_ASSIGNED 4
`define DPMC_ST_LATCHED 5
`define DPMC_ST_ENABLE 6

// Timing
`define DPMC_CLK_NS 20
`define DPMC_UPDATE_NS 2000
`define DPMC_UPDATE_CYC (`DPMC_UPDATE_NS / `DPMC_CLK_NS)

`endif

// >>> rtl/dpmc_pkg.sv
/*
  Types of the dancer tension control block.
  Assumes nothing beyond the constants header.
*/
package dpmc_pkg;
  // Ratio divider sequencer
  typedef enum logic {
    DPMC_DIV_IDLE,
    DPMC_DIV_RUN
  } dpmc_div_state_type;
  // One terminal function selector
  typedef logic [7:0] dpmc_sel_type;
endpackage

// >>> verif/dpmc_monitor.sv
/* Port checker for dpmc_top: bus handshake, tick timing, output ranges.
   Assumes a high synchronous reset and a tick every UPDATE_CYC clocks. */
`timescale 1ns/1ns
module dpmc_monitor #(
  parameter int N_OUT = 3,
  parameter int UPDATE_CYC = 100
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Bus strobe
  input wire logic ack_o, // Bus acknowledge
  input wire logic [31:0] dat_o, // Read data
  input wire logic [N_OUT-1:0] out_term_o, // Terminals
  input wire logic [15:0] main_speed_i, // Main speed
  input wire logic [15:0] speed_cmd_o, // Speed out
  input wire logic [15:0] set_point_o, // Set point
  input wire logic [15:0] feedback_pct_o, // Measured value
  input wire logic pid_reverse_o, // Reverse action
  input wire logic tension_active_o // Loop active
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int cnt; // Cycles since last tick
  // Tick counter, restarts with reset like the design's
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt == UPDATE_CYC - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  AST_ACK_ONE: assert property (s_req |=> s_ans) // Fixed one wait state
    else $error("ack not one cycle after request");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) // Only answers requests
    else $error("ack without request");
  AST_DAT_HIGH: assert property (ack_o |-> dat_o[31:16] == 16'h0000) // Narrow registers
    else $error("upper read bits set");
  // Outputs load on the edge after the tick, so a change is seen with cnt at 1
  AST_TICK_ONLY: assert property ($changed({out_term_o, speed_cmd_o, set_point_o,
    feedback_pct_o, pid_reverse_o, tension_active_o}) |-> cnt == 1)
    else $error("output moved off tick");
  AST_PLAIN_SPEED: assert property (!tension_active_o && $changed(speed_cmd_o)
    |-> speed_cmd_o == $past(main_speed_i)) else $error("plain speed wrong");
  AST_SETPT_MAX: assert property (set_point_o <= 16'h03E8)
    else $error("set point out of range");
  AST_FB_CLAMP: assert property (feedback_pct_o <= 16'h03E8)
    else $error("measured value not clamped");
  AST_ACTIVE_HOLD: assert property ($rose(tension_active_o) |=> $stable(tension_active_o)[*3])
    else $error("active flag glitch");
endmodule
bind dpmc_top dpmc_monitor #(.N_OUT(N_OUT), .UPDATE_CYC(UPDATE_CYC)) dpmc_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
  .out_term_o(out_term_o), .main_speed_i(main_speed_i), .speed_cmd_o(speed_cmd_o),
  .set_point_o(set_point_o), .feedback_pct_o(feedback_pct_o), .pid_reverse_o(pid_reverse_o),
  .tension_active_o(tension_active_o));

// >>> verif/dpmc_sensor_model.sv
/* Dancer position sensor and input contacts as seen by the drive.
   Assumes position in 0.1 % steps and the design's 10-bit converter. */
`timescale 1ns/1ns
module dpmc_sensor_model (
  input wire logic clk_i, // Clock
  input wire logic [1:0] scale_i, // Wiring of the sensor
  input wire logic [15:0] pos_i, // Position, 0.1 %
  input wire logic [6:0] press_i, // Contacts to close
  output logic [9:0] raw_o, // Converter code
  output logic [6:0] term_o // Terminal levels
);
  // Converter follows position; 5 V fills half the code range
  always_ff @(posedge clk_i) begin
    case (scale_i)
      2'h1: raw_o <= 10'((pos_i * 1024) / 2000);
      2'h2: raw_o <= 10'((pos_i * 1023) / 1000);
      default: raw_o <= 10'(205 + (pos_i * 818) / 1000); // Live zero at 4 mA
    endcase
    term_o <= press_i; // Contact closure
  end
endmodule

// >>> verif/dpmc_top_bench.sv
/* Self-checking bench for dpmc_top with a sensor model and bus tasks.
   Assumes the bindable checker and a shortened update tick. */
`timescale 1ns/1ns
module dpmc_top_bench;
  localparam int U = 40; // Tick, long enough for the ratio divider
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, running_i = 0;
  logic dir_forward_i = 0, pid_reverse_o, tension_active_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q, rs = 32'h6A52;
  logic [6:0] in_term_i, press = 7'h00;
  logic [9:0] raw;
  logic [1:0] scale = 2'h0;
  logic [2:0] out_term_o;
  logic [15:0] main_speed_i = 16'h0BB8, output_freq_i = 16'h07D0, pos = 16'h0000;
  logic [15:0] speed_cmd_o, set_point_o, feedback_pct_o;
  logic signed [15:0] pid_correction_i = 16'sh0064;
  int mismatches = 0, n_tests = 0;
  always #10 clk_i = ~clk_i;
  dpmc_top #(.UPDATE_CYC(U)) dpmc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .in_term_i(in_term_i), .feedback_raw_i(raw), .main_speed_i(main_speed_i),
    .output_freq_i(output_freq_i), .running_i(running_i), .dir_forward_i(dir_forward_i),
    .pid_correction_i(pid_correction_i), .out_term_o(out_term_o), .speed_cmd_o(speed_cmd_o),
    .set_point_o(set_point_o), .feedback_pct_o(feedback_pct_o),
    .pid_reverse_o(pid_reverse_o), .tension_active_o(tension_active_o));
  dpmc_sensor_model dpmc_sensor_model_inst (.clk_i(clk_i), .scale_i(scale), .pos_i(pos),
    .press_i(press), .raw_o(raw), .term_o(in_term_i));
  // Fixed-seed generator
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Measured value model, clamped to full scale
  function automatic int pct(int c, int s);
    int p;
    p = (s == 1) ? (c * 2000) >>> 10 : (s == 2) ? (c * 1000) >>> 10 : ((c - 205) * 1250) >>> 10;
    return (p > 1000) ? 1000 : p;
  endfunction
  // Speed model: gain 5000, bias 0, ratio in Q12
  function automatic int spd(int base, int corr, bit ratio);
    int c;
    c = (corr * 5000 * 1049) >>> 20;
    if (ratio) begin
      c = (c * ((base * 4096) / 5000)) >>> 12;
    end
    return base + c;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, m, seen, exp);
    end
  endtask
  // Classic single cycle; ack and read data taken at the same rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t bus: no ack", $time);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  task automatic tk(input int n);
    repeat (n * U) @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard, far beyond the planned run
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0, "action rst");
    rd(8'h2C, 32'h270F, "upper rst");
    rd(8'h34, 32'h270F, "setpt rst");
    rd(8'h38, 32'h0, "scale rst");
    rd(8'h3C, 32'h1388, "gain rst");
    rd(8'h7C, 32'h0, "unmapped");
    tk(2);
    chk(set_point_o, 32'd500, "fixed sp");
    wr(8'h34, 32'd700);
    tk(2);
    chk(set_point_o, 32'd700, "set sp");
    $display("test setpoint done");
    for (int s = 0; s < 3; s++) begin
      scale <= 2'(s);
      pos <= 16'(xs() % 1000);
      wr(8'h38, 32'(s));
      tk(2);
      chk(feedback_pct_o, 32'(pct(int'(raw), s)), "scaling");
    end
    $display("test scaling done");
    wr(8'h20, 32'd16);
    wr(8'h24, 32'd115);
    wr(8'h28, 32'd47);
    running_i <= 1'b1;
    dir_forward_i <= 1'b1;
    tk(2);
    chk(32'(out_term_o), 32'h3, "plain terms");
    chk(speed_cmd_o, 32'd3000, "plain speed");
    dir_forward_i <= 1'b0;
    running_i <= 1'b0;
    pos <= 16'd800;
    wr(8'h2C, 32'd600);
    wr(8'h00, 32'd41);
    tk(2);
    chk(32'(out_term_o), 32'h4, "dir off, upper neg");
    chk(tension_active_o, 32'h1, "sel enables");
    rd(8'h48, 32'h43, "status");
    chk(speed_cmd_o, 32'(spd(3000, 100, 0)), "fixed add");
    wr(8'h24, 32'd14);
    wr(8'h30, 32'd900);
    tk(2);
    chk(out_term_o[1], 32'h1, "lower on");
    wr(8'h30, 32'h270F);
    tk(2);
    chk(out_term_o[1], 32'h0, "lower none");
    $display("test flags done");
    wr(8'h10, 32'd14);
    tk(2);
    chk(tension_active_o, 32'h0, "enable low");
    running_i <= 1'b1;
    press <= 7'h08;
    tk(2);
    chk(tension_active_o, 32'h1, "enable high");
    chk(speed_cmd_o, 32'(spd(2000, 100, 0)), "latched base");
    press <= 7'h00;
    tk(2);
    chk(speed_cmd_o, 32'd3000, "resume set");
    $display("test enable done");
    running_i <= 1'b0;
    main_speed_i <= 16'd2500;
    wr(8'h10, 32'd0);
    wr(8'h44, 32'd1000);
    for (int a = 40; a < 44; a++) begin
      wr(8'h00, 32'(a));
      tk(3);
      chk(pid_reverse_o, 32'(a == 40 || a == 42), "action dir");
      chk(speed_cmd_o, 32'(spd(2500, 100, a > 41)), "add method");
    end
    $display("test actions done");
    stop_test();
  end
endmodule
